// >>> verilog/gpc_pkg.sv
// Purpose: Constants for the three-pin general-purpose port control register.
// Assumes: Register reached through the device command path as a byte port.
// Notes: Bit positions and reset value of the port control byte.
package gpc_pkg;
	localparam int REG_WIDTH = 8;
	localparam int NUM_PINS = 3;
	localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
	localparam int BIT_RESERVED = 7;
	localparam int BIT_PIN2_DIR = 6;
	localparam int BIT_PIN1_DIR = 5;
	localparam int BIT_PIN0_DIR = 4;
	localparam int BIT_PIN2_SRC = 3;
	localparam int BIT_PIN2_LEVEL = 2;
	localparam int BIT_PIN1_LEVEL = 1;
	localparam int BIT_PIN0_LEVEL = 0;
	localparam int DIR_LSB = 4;
	localparam int LEVEL_LSB = 0;
endpackage : gpc_pkg

// >>> verilog/gpc_sync2.sv
// Purpose: Two-flop synchroniser for one pin level.
// Assumes: Input arrives asynchronously to clk_i.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module gpc_sync2 (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta;
	logic next_meta;
	logic next_sync;

	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule : gpc_sync2

// >>> verilog/gpc_port.sv
// Purpose: Three-pin general-purpose port with one control byte.
// Assumes: Command decoder delivers register writes and reads as strobes.
// Notes: Input-pin level bits mirror synchronised pins; writes to them drop.
`timescale 1ns/1ps
module gpc_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic result_ready_n_i,
	input wire logic general_pin_0_i,
	input wire logic general_pin_1_i,
	input wire logic general_pin_2_i,
	output logic general_pin_0_o,
	output logic general_pin_1_o,
	output logic general_pin_2_o,
	output logic general_pin_0_oe_o,
	output logic general_pin_1_oe_o,
	output logic general_pin_2_oe_o
);
	////////////////////////////////////////////////////////////////////////////
	logic [2:0] pin_in;
	logic [2:0] pin_sync;
	logic [2:0] dir;
	logic [2:0] level;
	logic pin2_source_select;
	logic [2:0] next_dir;
	logic [2:0] next_level;
	logic next_src;
	logic [7:0] port_view;
	logic [7:0] next_rd_data;
	logic next_rd_valid;
	logic [2:0] next_pin_out;
	logic [2:0] next_pin_oe;
	logic [2:0] pin_out;
	logic [2:0] pin_oe;

	assign pin_in = {general_pin_2_i, general_pin_1_i, general_pin_0_i};

	genvar g;
	generate
		for (g = 0; g < gpc_pkg::NUM_PINS; g++) begin : g_sync
			gpc_sync2 u_sync (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.async_i(pin_in[g]),
				.sync_o(pin_sync[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Register state
	always_comb begin
		next_dir = dir;
		next_level = level;
		next_src = pin2_source_select;
		if (wr_en_i) begin
			next_dir = wr_data_i[gpc_pkg::BIT_PIN2_DIR:gpc_pkg::BIT_PIN0_DIR];
			next_src = wr_data_i[gpc_pkg::BIT_PIN2_SRC];
			// Level kept only for pins that end up as outputs after this write
			for (int i = 0; i < 3; i++) begin
				if (wr_data_i[gpc_pkg::DIR_LSB + i]) begin
					next_level[i] = wr_data_i[gpc_pkg::LEVEL_LSB + i];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir <= gpc_pkg::PORT_CTRL_RESET[gpc_pkg::BIT_PIN2_DIR:gpc_pkg::BIT_PIN0_DIR];
			level <= gpc_pkg::PORT_CTRL_RESET[gpc_pkg::BIT_PIN2_LEVEL:gpc_pkg::BIT_PIN0_LEVEL];
			pin2_source_select <= gpc_pkg::PORT_CTRL_RESET[gpc_pkg::BIT_PIN2_SRC];
		end else begin
			dir <= next_dir;
			level <= next_level;
			pin2_source_select <= next_src;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readback and pin drive
	always_comb begin
		port_view = 8'h00; // Reserved bit 7 reads zero
		port_view[gpc_pkg::BIT_PIN2_DIR:gpc_pkg::BIT_PIN0_DIR] = dir;
		port_view[gpc_pkg::BIT_PIN2_SRC] = pin2_source_select;
		for (int i = 0; i < 3; i++) begin
			port_view[gpc_pkg::LEVEL_LSB + i] = dir[i] ? level[i] : pin_sync[i];
		end
		next_rd_data = rd_en_i ? port_view : rd_data_o;
		next_rd_valid = rd_en_i;
		next_pin_oe = dir;
		next_pin_out = level;
		if (pin2_source_select) begin
			next_pin_out[2] = result_ready_n_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			pin_out <= 3'h0;
			pin_oe <= 3'h0;
		end else begin
			rd_data_o <= next_rd_data;
			rd_valid_o <= next_rd_valid;
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

	// Direct flop outputs; one cycle of lag after a write is accepted
	assign general_pin_0_o = pin_out[0];
	assign general_pin_1_o = pin_out[1];
	assign general_pin_2_o = pin_out[2];
	assign general_pin_0_oe_o = pin_oe[0];
	assign general_pin_1_oe_o = pin_oe[1];
	assign general_pin_2_oe_o = pin_oe[2];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_dir_follows_write;
		@(posedge clk_i) disable iff (rst_i)
		wr_en_i |=> ##1 (pin_oe == $past(wr_data_i[6:4], 2));
	endproperty
	a_dir_follows_write: assert property (p_dir_follows_write) else $error("oe not from dir");

	property p_pin1_dir;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && wr_data_i[5]) |=> ##1 general_pin_1_oe_o;
	endproperty
	a_pin1_dir: assert property (p_pin1_dir) else $error("pin1 not output");

	property p_pin0_dir;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && !wr_data_i[4]) |=> ##1 !general_pin_0_oe_o;
	endproperty
	a_pin0_dir: assert property (p_pin0_dir) else $error("pin0 not input");

	sequence s_src_ready;
		!rst_i && dir[2] && pin2_source_select;
	endsequence
	property p_src_ready;
		@(posedge clk_i) disable iff (rst_i)
		s_src_ready |=> (general_pin_2_o == $past(result_ready_n_i));
	endproperty
	a_src_ready: assert property (p_src_ready) else $error("pin2 not ready");

	property p_pin2_level;
		@(posedge clk_i) disable iff (rst_i)
		(dir[2] && !pin2_source_select) |=> (general_pin_2_o == $past(level[2]));
	endproperty
	a_pin2_level: assert property (p_pin2_level) else $error("pin2 level wrong");

	property p_pin1_read;
		@(posedge clk_i) disable iff (rst_i)
		(rd_en_i && !dir[1]) |=> (rd_data_o[1] == $past(pin_sync[1]));
	endproperty
	a_pin1_read: assert property (p_pin1_read) else $error("pin1 read wrong");

	property p_pin0_out;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && wr_data_i[4]) |=> ##1 (general_pin_0_o == $past(wr_data_i[0], 2));
	endproperty
	a_pin0_out: assert property (p_pin0_out) else $error("pin0 level wrong");

	// No sampled-value call here: the first edge has no history to look back on
	property p_reset_state;
		@(posedge clk_i) rst_i |=> (dir == 3'h0 && level == 3'h0 && !pin2_source_select);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	property p_input_write_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && !wr_data_i[5]) |=> (level[1] == $past(level[1]));
	endproperty
	a_input_write_ignored: assert property (p_input_write_ignored) else $error("input write");

	property p_input_level_held;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && !wr_data_i[6]) |=> (level[2] == $past(level[2]));
	endproperty
	a_input_level_held: assert property (p_input_level_held) else $error("pin2 input write");

	property p_pin2_dir;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && wr_data_i[6]) |=> ##1 general_pin_2_oe_o;
	endproperty
	a_pin2_dir: assert property (p_pin2_dir) else $error("pin2 not output");

	property p_pin1_out;
		@(posedge clk_i) disable iff (rst_i)
		(wr_en_i && wr_data_i[5]) |=> ##1 (general_pin_1_o == $past(wr_data_i[1], 2));
	endproperty
	a_pin1_out: assert property (p_pin1_out) else $error("pin1 level wrong");

	property p_reset_outputs;
		@(posedge clk_i) rst_i |=> (pin_oe == 3'h0 && !rd_valid_o);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("reset outputs wrong");

	////////////////////////////////////////////////////////////////////////////
	// Readback handshake checks
	sequence s_read_req;
		rd_en_i;
	endsequence

	sequence s_read_idle;
		!rd_en_i;
	endsequence

	// Reserved bit must never leak a stored value into the readback
	property p_rd_answer;
		@(posedge clk_i) disable iff (rst_i)
		s_read_req |=> (rd_valid_o && !rd_data_o[gpc_pkg::BIT_RESERVED]);
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

	// The command path may pick the byte up late, so it must hold between reads
	property p_rd_idle;
		@(posedge clk_i) disable iff (rst_i)
		s_read_idle |=> (!rd_valid_o && $stable(rd_data_o));
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data moved");

	property p_pin2_read;
		@(posedge clk_i) disable iff (rst_i)
		(rd_en_i && !dir[2]) |=> (rd_data_o[2] == $past(pin_sync[2]));
	endproperty
	a_pin2_read: assert property (p_pin2_read) else $error("pin2 read wrong");

	property p_pin0_read;
		@(posedge clk_i) disable iff (rst_i)
		(rd_en_i && !dir[0]) |=> (rd_data_o[0] == $past(pin_sync[0]));
	endproperty
	a_pin0_read: assert property (p_pin0_read) else $error("pin0 read wrong");
endmodule : gpc_port

// >>> bench/gpc_board.sv
// Purpose: Board side of the three port pins.
// Assumes: Bench sets the level each pin sees when released.
// Notes: Pins driven by the port show the driven level.
`timescale 1ns/1ps
module gpc_board (
	input wire logic [2:0] drv_i,
	input wire logic [2:0] pin_o_i,
	input wire logic [2:0] oe_i,
	output logic [2:0] wire_o
);
	// A released pin shows the board level, never the last driven one
	always_comb for (int i = 0; i < 3; i++) wire_o[i] = oe_i[i] ? pin_o_i[i] : drv_i[i];
endmodule : gpc_board

// >>> bench/adc_three_pin_gpio_control_bench.sv
// Purpose: Self-checking bench for the port control byte.
// Assumes: Board levels held several cycles before each read.
// Notes: Model keeps direction, source and stored levels as ints.
`timescale 1ns/1ps
module adc_three_pin_gpio_control_bench;
	logic clk_i = 0, rst_i = 1, wr_en_i = 0, rd_en_i = 0, rrn = 1, rd_valid_o;
	logic [7:0] wr_data_i = 8'h00, rd_data_o;
	logic [2:0] drv = 3'h0, po, oe, wl;
	int n_errors = 0, check_count = 0, cyc = 0, seed = 32'hd7ec8a97, dir = 0, src = 0, lev = 0;
	always #25 clk_i = ~clk_i;
	gpc_port gpc_port_i (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
		.wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .result_ready_n_i(rrn), .general_pin_0_i(wl[0]),
		.general_pin_1_i(wl[1]), .general_pin_2_i(wl[2]), .general_pin_0_o(po[0]),
		.general_pin_1_o(po[1]), .general_pin_2_o(po[2]), .general_pin_0_oe_o(oe[0]),
		.general_pin_1_oe_o(oe[1]), .general_pin_2_oe_o(oe[2]));
	gpc_board gpc_board_i (.drv_i(drv), .pin_o_i(po), .oe_i(oe), .wire_o(wl));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d);
		@(posedge clk_i);
		// One strobe stands for one whole host command, sync word already consumed
		wr_en_i <= 1'b1;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
		dir = d[6:4];
		src = d[3];
		lev = (lev & ~dir) | (d[2:0] & dir);
	endtask : wr
	// Reads compare byte, handshake, enables and driven levels with the model
	task automatic rd_all();
		logic [2:0] lv, pe;
		lv = (3'(lev) & 3'(dir)) | (drv & ~3'(dir));
		pe = {(src != 0) ? rrn : 1'(lev >> 2), 2'(lev)};
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1;
		chk("valid", 8'h01, {7'h00, rd_valid_o});
		chk("byte", {1'b0, 3'(dir), 1'(src), lv}, rd_data_o);
		chk("oe", {5'h00, 3'(dir)}, {5'h00, oe});
		chk("pins", {5'h00, pe & 3'(dir)}, {5'h00, po & oe});
		@(posedge clk_i);
		#1;
		chk("valid low", 8'h00, {7'h00, rd_valid_o});
		chk("byte held", {1'b0, 3'(dir), 1'(src), lv}, rd_data_o);
	endtask : rd_all
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc > 4000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_all();
		$display("Test reset done");
		for (int n = 0; n < 150; n++) begin
			@(posedge clk_i);
			drv <= 3'($random(seed));
			rrn <= 1'($random(seed));
			wr(8'($random(seed)));
			repeat (4) @(posedge clk_i);
			rd_all();
		end
		$display("Test random writes done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		// Synchronisers restart from zero, so let the board levels pass both stages
		repeat (2) @(posedge clk_i);
		dir = 0;
		src = 0;
		lev = 0;
		rd_all();
		$display("Test second reset done");
		tally_and_finish();
	end
endmodule : adc_three_pin_gpio_control_bench
